// *** csb_pkg.sv ***
// constants, field layouts and carrier types of the cluster sideband block
// assumes one clock, an AHB-Lite master with word transfers, up to four cores

package csb_pkg;

   // register byte offsets, one word each
   localparam logic [7:0] OFS_SYSCTL0  = 8'h00; // one per core, step 4
   localparam logic [7:0] OFS_AFFIN0   = 8'h10; // one per core, step 4
   localparam logic [7:0] OFS_CFGBASE  = 8'h20;
   localparam logic [7:0] OFS_WIN_CTRL = 8'h24;
   localparam logic [7:0] OFS_WIN_LOW  = 8'h28;
   localparam logic [7:0] OFS_WIN_HIGH = 8'h2C;
   localparam logic [7:0] OFS_STANDBY  = 8'h30;
   localparam logic [7:0] OFS_STEP     = 8'h04;

   // field positions
   localparam int unsigned AFF_CLUSTER_LSB = 8;
   localparam int unsigned BASE_LSB        = 13;
   localparam int unsigned WIN_LSB         = 20;
   localparam int unsigned STBY_WFI_LSB    = 8;
   localparam int unsigned CORES_MAX       = 4;

   // bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   // per-core system control bits, low bits of the register
   typedef struct packed {
      logic smp;            // symmetric mode, never locked
      logic vec_high;       // high vectors
      logic instr_compact;  // compact instruction set on exceptions
      logic nonmask_fast_irq_bit;           // non-maskable fast interrupts
      logic big_endian;     // big-endian exception handling
   } csb_sysctl_type;

   localparam int unsigned SC_W = $bits(csb_sysctl_type);

   // reset strap bundle of one core
   typedef struct packed {
      logic endian;
      logic nonmask_fast_irq_bit;
      logic instr;
      logic vec_high;
   } csb_strap_type;

   // captured address phase
   typedef struct packed {
      logic [7:0] addr;
      logic       write;
   } csb_addr_phase_type;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_WAIT_EVENT,
      ST_WAIT_IRQ
   } csb_core_state_type;

endpackage : csb_pkg

// *** csb_core_standby.sv ***
// wait-for-event and wait-for-interrupt standby tracker of one core
// assumes request and wake inputs are single-cycle pulses in mclk_i
`timescale 1ns/100ps

module csb_core_standby (
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   input  wire logic core_in_reset_i,
   input  wire logic wait_for_event_i,
   input  wire logic wait_for_interrupt_i,
   input  wire logic wake_i,
   input  wire logic irq_pending_i,
   output logic      wait_event_standby_o,
   output logic      wait_irq_standby_o
);

   csb_pkg::csb_core_state_type state;
   csb_pkg::csb_core_state_type next_state;
   logic                        event_latch;
   logic                        next_event_latch;

   // next state and event latch; a wake arriving with a consume still sets
   always_comb begin
      next_state       = state;
      next_event_latch = event_latch;
      case (state)
         csb_pkg::ST_RUN: begin
            if (wait_for_interrupt_i) begin
               next_state = csb_pkg::ST_WAIT_IRQ;
            end else if (wait_for_event_i) begin
               if (event_latch) begin
                  next_event_latch = 1'b0; // pending event consumed
               end else begin
                  next_state = csb_pkg::ST_WAIT_EVENT;
               end
            end
         end
         csb_pkg::ST_WAIT_EVENT: begin
            if (wake_i || irq_pending_i) begin
               next_state = csb_pkg::ST_RUN;
            end
         end
         csb_pkg::ST_WAIT_IRQ: begin
            if (irq_pending_i) begin
               next_state = csb_pkg::ST_RUN;
            end
         end
         default: begin
            next_state = csb_pkg::ST_RUN;
         end
      endcase
      if (wake_i && !(state == csb_pkg::ST_WAIT_EVENT)) begin
         next_event_latch = 1'b1;
      end
      if (core_in_reset_i) begin
         next_state       = csb_pkg::ST_RUN;
         next_event_latch = 1'b0;
      end
   end

   // state and indicator flops
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state                <= csb_pkg::ST_RUN;
         event_latch          <= 1'b0;
         wait_event_standby_o <= 1'b0;
         wait_irq_standby_o   <= 1'b0;
      end else begin
         state                <= next_state;
         event_latch          <= next_event_latch;
         wait_event_standby_o <= next_state == csb_pkg::ST_WAIT_EVENT;
         wait_irq_standby_o   <= next_state == csb_pkg::ST_WAIT_IRQ;
      end
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_wfe_enter: assert property (
      (state == csb_pkg::ST_RUN && wait_for_event_i && !event_latch
       && !wait_for_interrupt_i && !core_in_reset_i && !wake_i)
      |=> wait_event_standby_o ##1 (wait_event_standby_o || $past(wake_i)
          || $past(irq_pending_i) || $past(core_in_reset_i)))
      else $error("wfe standby not entered");
   a_wfi_enter: assert property (
      (state == csb_pkg::ST_RUN && wait_for_interrupt_i && !core_in_reset_i)
      |=> wait_irq_standby_o && !wait_event_standby_o)
      else $error("wfi standby not entered");
   a_wake_exit: assert property (
      (wait_event_standby_o && wake_i) |=> !wait_event_standby_o)
      else $error("event did not wake core");
   c_wfe_wake: cover property (wait_event_standby_o ##1 !wait_event_standby_o);

endmodule : csb_core_standby

// *** csb_cluster_sideband.sv ***
// cluster configuration, security lock and standby sideband with AHB-Lite
// assumes straps and configuration inputs synchronous to mclk_i and a single
// AHB-Lite master doing word transfers; core activity arrives as pulses
`timescale 1ns/100ps

module csb_cluster_sideband #(
   parameter int unsigned NUM_CORES   = 4,
   parameter bit          DUAL_MASTER = 1'b1
) (
   input  wire logic                 mclk_i,
   input  wire logic                 rst_n_i,
   // per-core reset level and reset straps
   input  wire logic [NUM_CORES-1:0] core_in_reset_i,
   input  wire logic [NUM_CORES-1:0] endian_strap_i,
   input  wire logic [NUM_CORES-1:0] nonmask_fast_irq_strap_i,
   input  wire logic [NUM_CORES-1:0] initial_instr_set_strap_i,
   input  wire logic [NUM_CORES-1:0] high_vector_strap_i,
   // static configuration
   input  wire logic [3:0]           cluster_number_in_i,
   input  wire logic                 addr_window_on_i,
   input  wire logic [11:0]          addr_window_low_i,
   input  wire logic [11:0]          addr_window_high_i,
   input  wire logic [18:0]          private_region_base_i,
   // security locks
   input  wire logic                 global_secure_write_lock_i,
   input  wire logic [NUM_CORES-1:0] core_secure_write_lock_i,
   // core activity and events
   input  wire logic                 wake_event_in_i,
   input  wire logic [NUM_CORES-1:0] send_event_instr_i,
   input  wire logic [NUM_CORES-1:0] wait_for_event_i,
   input  wire logic [NUM_CORES-1:0] wait_for_interrupt_i,
   input  wire logic [NUM_CORES-1:0] irq_pending_i,
   output logic      [NUM_CORES-1:0] symmetric_mode_out_o,
   output logic                      send_event_out_o,
   output logic      [NUM_CORES-1:0] wait_event_standby_out_o,
   output logic      [NUM_CORES-1:0] wait_irq_standby_out_o,
   // AHB-Lite slave
   input  wire logic                 hsel_i,
   input  wire logic [31:0]          haddr_i,
   input  wire logic [1:0]           htrans_i,
   input  wire logic                 hwrite_i,
   input  wire logic [2:0]           hsize_i,
   input  wire logic [31:0]          hwdata_i,
   input  wire logic                 hready_i,
   output logic      [31:0]          hrdata_o,
   output logic                      hreadyout_o,
   output logic                      hresp_o
);

   // true when a is the byte offset of register n of a per-core bank
   function automatic logic core_hit(input logic [7:0] a,
                                     input logic [7:0] base,
                                     input int unsigned n);
      core_hit = a == 8'(base + 8'(n) * csb_pkg::OFS_STEP);
   endfunction : core_hit

   // number of set bits in a core vector
   function automatic logic [3:0] count_ones(input logic [NUM_CORES-1:0] v);
      count_ones = 4'h0;
      for (int unsigned i = 0; i < NUM_CORES; i++) begin
         count_ones = count_ones + 4'(v[i]);
      end
   endfunction : count_ones

   csb_pkg::csb_sysctl_type     sysctl      [NUM_CORES];
   csb_pkg::csb_sysctl_type     next_sysctl [NUM_CORES];
   csb_pkg::csb_strap_type      strap       [NUM_CORES];
   csb_pkg::csb_sysctl_type     wr_val;
   csb_pkg::csb_addr_phase_type aphase;
   csb_pkg::csb_addr_phase_type next_aphase;
   logic                        dphase_wr;
   logic                        next_dphase_wr;
   logic                        rd_wait;
   logic                        next_rd_wait;
   logic                        ready_out;
   logic                        next_ready_out;
   logic [31:0]                 rdata;
   logic [31:0]                 next_rdata;
   logic [31:0]                 read_word;
   logic                        win_loaded;
   logic                        win_on;
   logic [11:0]                 win_low;
   logic                        next_win_loaded;
   logic                        next_win_on;
   logic [11:0]                 next_win_low;
   logic [3:0]                  sev_pending;
   logic [3:0]                  next_sev_pending;
   logic                        sev_out;
   logic                        next_sev_out;
   logic                        any_sev;

   // strap bundles per core
   always_comb begin
      for (int unsigned n = 0; n < NUM_CORES; n++) begin
         strap[n] = '{endian:   endian_strap_i[n],
                      nonmask_fast_irq_bit:     nonmask_fast_irq_strap_i[n],
                      instr:    initial_instr_set_strap_i[n],
                      vec_high: high_vector_strap_i[n]};
      end
   end

   // bus side: address phase capture, one wait state on reads
   always_comb begin
      next_aphase    = aphase;
      next_dphase_wr = 1'b0;
      next_rd_wait   = 1'b0;
      next_ready_out = 1'b1;
      next_rdata     = rdata;
      if (rd_wait) begin
         next_rdata = read_word;
      end else if (hsel_i && htrans_i == csb_pkg::HTRANS_NONSEQ
                   && hready_i) begin
         next_aphase = '{addr: haddr_i[7:0], write: hwrite_i};
         if (hwrite_i) begin
            next_dphase_wr = 1'b1;
         end else begin
            next_rd_wait   = 1'b1;
            next_ready_out = 1'b0;
         end
      end
   end

   // bus flops
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aphase    <= '0;
         dphase_wr <= 1'b0;
         rd_wait   <= 1'b0;
         ready_out <= 1'b1;
         rdata     <= 32'h0000_0000;
      end else begin
         aphase    <= next_aphase;
         dphase_wr <= next_dphase_wr;
         rd_wait   <= next_rd_wait;
         ready_out <= next_ready_out;
         rdata     <= next_rdata;
      end
   end

   // read multiplexer; unmapped words read as zero
   always_comb begin
      read_word = 32'h0000_0000;
      for (int unsigned n = 0; n < NUM_CORES; n++) begin
         if (core_hit(aphase.addr, csb_pkg::OFS_SYSCTL0, n)) begin
            read_word = {{(32 - csb_pkg::SC_W){1'b0}}, sysctl[n]};
         end
         if (core_hit(aphase.addr, csb_pkg::OFS_AFFIN0, n)) begin
            read_word = {20'h0_0000, cluster_number_in_i, 8'(n)};
         end
      end
      case (aphase.addr)
         csb_pkg::OFS_CFGBASE: begin
            read_word = {private_region_base_i, 13'h0000};
         end
         csb_pkg::OFS_WIN_CTRL: begin
            read_word = {31'h0000_0000, win_on};
         end
         csb_pkg::OFS_WIN_LOW: begin
            read_word = {win_low, 20'h0_0000};
         end
         csb_pkg::OFS_WIN_HIGH: begin
            read_word = {addr_window_high_i, 20'h0_0000};
         end
         csb_pkg::OFS_STANDBY: begin
            read_word[NUM_CORES-1:0] = wait_event_standby_out_o;
            read_word[csb_pkg::STBY_WFI_LSB +: NUM_CORES] =
               wait_irq_standby_out_o;
         end
         default: begin
            read_word = read_word;
         end
      endcase
   end

   // per-core control bits: straps during core reset, writes after, lock-guarded except smp
   always_comb begin
      wr_val = csb_pkg::csb_sysctl_type'(hwdata_i[csb_pkg::SC_W-1:0]);
      for (int unsigned n = 0; n < NUM_CORES; n++) begin
         next_sysctl[n] = sysctl[n];
         if (core_in_reset_i[n]) begin
            next_sysctl[n].big_endian    = strap[n].endian;
            next_sysctl[n].nonmask_fast_irq_bit          = strap[n].nonmask_fast_irq_bit;
            next_sysctl[n].instr_compact = strap[n].instr;
            next_sysctl[n].vec_high      = strap[n].vec_high;
            next_sysctl[n].smp           = 1'b0;
         end else if (dphase_wr
                      && core_hit(aphase.addr, csb_pkg::OFS_SYSCTL0, n)) begin
            next_sysctl[n].smp = wr_val.smp;
            if (!global_secure_write_lock_i
                && !core_secure_write_lock_i[n]) begin
               next_sysctl[n].big_endian    = wr_val.big_endian;
               next_sysctl[n].nonmask_fast_irq_bit          = wr_val.nonmask_fast_irq_bit;
               next_sysctl[n].instr_compact = wr_val.instr_compact;
               next_sysctl[n].vec_high      = wr_val.vec_high;
            end
         end
      end
   end

   // control bit flops; straps ignored outside core reset
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int unsigned n = 0; n < NUM_CORES; n++) begin
            sysctl[n] <= '0;
         end
      end else begin
         for (int unsigned n = 0; n < NUM_CORES; n++) begin
            sysctl[n] <= next_sysctl[n];
         end
      end
   end

   // window switch and low bound caught once, in the first cycle after reset release; high bound read live
   always_comb begin
      next_win_loaded = 1'b1;
      next_win_on     = win_on;
      next_win_low    = win_low;
      if (!win_loaded) begin
         next_win_on  = addr_window_on_i && DUAL_MASTER;
         next_win_low = addr_window_low_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         win_loaded <= 1'b0;
         win_on     <= 1'b0;
         win_low    <= 12'h000;
      end else begin
         win_loaded <= next_win_loaded;
         win_on     <= next_win_on;
         win_low    <= next_win_low;
      end
   end

   // send-event queue: one separated output pulse per instruction, up to 15 pending
   always_comb begin
      next_sev_pending = sev_pending;
      next_sev_out     = 1'b0;
      if (sev_pending != 4'h0 && !sev_out) begin
         next_sev_out     = 1'b1;
         next_sev_pending = sev_pending - 4'h1;
      end
      if (5'(next_sev_pending) + 5'(count_ones(send_event_instr_i))
          > 5'h0F) begin
         next_sev_pending = 4'hF; // saturate on a flood
      end else begin
         next_sev_pending = next_sev_pending + count_ones(send_event_instr_i);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sev_pending <= 4'h0;
         sev_out     <= 1'b0;
      end else begin
         sev_pending <= next_sev_pending;
         sev_out     <= next_sev_out;
      end
   end

   assign any_sev = wake_event_in_i || (send_event_instr_i != '0);

   // standby trackers, one per core
   for (genvar g = 0; g < NUM_CORES; g++) begin : g_core
      csb_core_standby u_standby (
         .mclk_i               (mclk_i),
         .rst_n_i              (rst_n_i),
         .core_in_reset_i      (core_in_reset_i[g]),
         .wait_for_event_i     (wait_for_event_i[g]),
         .wait_for_interrupt_i (wait_for_interrupt_i[g]),
         .wake_i               (any_sev),
         .irq_pending_i        (irq_pending_i[g]),
         .wait_event_standby_o (wait_event_standby_out_o[g]),
         .wait_irq_standby_o   (wait_irq_standby_out_o[g])
      );
      assign symmetric_mode_out_o[g] = sysctl[g].smp;
   end

   // bus outputs straight from flops, hresp tied to OKAY
   assign hrdata_o         = rdata;
   assign hreadyout_o      = ready_out;
   assign hresp_o          = csb_pkg::HRESP_OKAY;
   assign send_event_out_o = sev_out;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_endian_load: assert property (
      core_in_reset_i[0] |=> sysctl[0].big_endian == $past(endian_strap_i[0]))
      else $error("endian bit not loaded from strap");
   a_nonmask_fast_irq_bit_load: assert property (
      core_in_reset_i[0] |=> sysctl[0].nonmask_fast_irq_bit
                             == $past(nonmask_fast_irq_strap_i[0]))
      else $error("nonmask_fast_irq_bit bit not loaded from strap");
   a_instr_vec_load: assert property (
      core_in_reset_i[0] |=> sysctl[0].instr_compact
         == $past(initial_instr_set_strap_i[0])
         && sysctl[0].vec_high == $past(high_vector_strap_i[0]))
      else $error("instruction or vector bit not loaded");
   a_lock_holds: assert property (
      (!core_in_reset_i[0] && global_secure_write_lock_i)
      |=> $stable(sysctl[0].big_endian) && $stable(sysctl[0].vec_high))
      else $error("locked bits changed");
   a_core_lock: assert property (
      (!core_in_reset_i[0] && core_secure_write_lock_i[0])
      |=> $stable(sysctl[0].nonmask_fast_irq_bit) && $stable(sysctl[0].instr_compact))
      else $error("core lock did not hold bits");
   a_smp_write: assert property (
      (dphase_wr && aphase.addr == csb_pkg::OFS_SYSCTL0 && !core_in_reset_i[0])
      |=> symmetric_mode_out_o[0] == $past(hwdata_i[csb_pkg::SC_W-1]))
      else $error("mode output not following write");
   a_affinity_read: assert property (
      (rd_wait && aphase.addr == csb_pkg::OFS_AFFIN0)
      |=> hreadyout_o && hrdata_o[11:8] == $past(cluster_number_in_i))
      else $error("cluster number not returned");
   a_base_read: assert property (
      (rd_wait && aphase.addr == csb_pkg::OFS_CFGBASE)
      |=> hrdata_o[31:13] == $past(private_region_base_i))
      else $error("base address not returned");
   a_window_hold: assert property (
      win_loaded |=> $stable(win_low) && $stable(win_on))
      else $error("window settings changed after reset");
   a_sev_pulse: assert property (
      send_event_out_o |=> !send_event_out_o)
      else $error("event output not a single pulse");
   a_sev_emit: assert property (
      (send_event_instr_i[0] && sev_pending == 4'h0 && !sev_out)
      |=> ##1 send_event_out_o)
      else $error("send event not signalled");
   c_locked_write: cover property (dphase_wr && global_secure_write_lock_i);
   c_sev_two: cover property (send_event_out_o ##2 send_event_out_o);
   c_read_done: cover property (rd_wait ##1 hreadyout_o);

endmodule : csb_cluster_sideband

// *** csb_sys_model.sv ***
// partner model: system configuration driving core reset and reset straps
// assumes go_i is a one-cycle pulse on mclk_i; all cores reset together
`timescale 1ns/100ps

module csb_sys_model (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        go_i,
   input  wire logic [15:0] pat_i,
   output logic      [3:0]  core_rst_o,
   output logic      [15:0] strap_o
);
   logic [15:0] held;
   logic [1:0]  cnt;

   // straps steady in reset
   // outside reset the straps toggle, so late sampling shows up
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         held <= 16'h0000;
         cnt  <= 2'h0;
      end else if (go_i) begin
         held <= pat_i;
         cnt  <= 2'h3;
      end else if (cnt != 2'h0) begin
         cnt <= cnt - 2'h1;
      end else begin
         held <= ~held;
      end
   end

   // reset level while the count runs
   assign core_rst_o = {4{cnt != 2'h0}};
   assign strap_o    = held;
endmodule : csb_sys_model

// *** testbench.sv ***
// self-checking bench of the cluster sideband block over AHB-Lite
// assumes the partner model sequences core reset and straps
`timescale 1ns/100ps

module testbench;
   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        go = 1'b0, gl = 1'b0, wake = 1'b0, sevo, hro, hrs;
   logic        hsel = 1'b0, hwr = 1'b0, won = 1'b1;
   logic [1:0]  htr = 2'h0;
   logic [3:0]  cir, lc = 4'h0, send_event_instr = 4'h0, wait_for_event = 4'h0, wait_for_interrupt = 4'h0;
   logic [3:0]  irq = 4'h0, smp, wes, wis;
   logic [15:0] pat = 16'h0000, st;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrd, rdat, cfg, base;
   logic [31:0] r = 32'h0001_580B, pc;
   int          err_total = 0, samples_checked = 0, cyc = 0;

   csb_sys_model sysm (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .go_i(go),
      .pat_i(pat), .core_rst_o(cir), .strap_o(st));

   csb_cluster_sideband #(.NUM_CORES(4), .DUAL_MASTER(1'b1)) dut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .core_in_reset_i(cir),
      .endian_strap_i(st[3:0]), .nonmask_fast_irq_strap_i(st[7:4]),
      .initial_instr_set_strap_i(st[11:8]), .high_vector_strap_i(st[15:12]),
      .cluster_number_in_i(cfg[3:0]), .addr_window_on_i(won),
      .addr_window_low_i(cfg[15:4]), .addr_window_high_i(cfg[27:16]),
      .private_region_base_i(base[18:0]), .global_secure_write_lock_i(gl),
      .core_secure_write_lock_i(lc), .wake_event_in_i(wake),
      .send_event_instr_i(send_event_instr), .wait_for_event_i(wait_for_event),
      .wait_for_interrupt_i(wait_for_interrupt), .irq_pending_i(irq),
      .symmetric_mode_out_o(smp), .send_event_out_o(sevo),
      .wait_event_standby_out_o(wes), .wait_irq_standby_out_o(wis),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htr), .hwrite_i(hwr),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hro), .hrdata_o(hrd),
      .hreadyout_o(hro), .hresp_o(hrs));

   // clock and hang guard
   always #2.5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end

   function automatic logic [31:0] nx();
      r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
      return r;
   endfunction : nx

   // expected control word of core n after its reset
   function automatic logic [31:0] exp_sc(input logic [15:0] p, input int n);
      return {28'h0, p[12+n], p[8+n], p[4+n], p[n]};
   endfunction : exp_sc

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one single AHB-Lite word transfer, entered just after a rising edge
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htr <= csb_pkg::HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwr <= w;
      @(posedge mclk_i);
      while (hro !== 1'b1) @(posedge mclk_i);
      hsel <= 1'b0;
      htr <= 2'h0;
      hwdata <= d;
      @(posedge mclk_i);
      while (hro !== 1'b1) @(posedge mclk_i);
      rdat = hrd;
      chk("hresp", 32'h0, {31'h0, hrs});
   endtask : ahb

   task conclude();
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude

   // main sequence; base and window bounds stay static, the window switch drops before the mid-run reset
   initial begin
      cfg = nx();
      base = nx();
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      ahb(1'b0, 8'h00, 32'h0);
      chk("sysctl after reset", 32'h0, rdat);
      wait_for_event <= 4'h4;
      @(posedge mclk_i) wait_for_event <= 4'h0;
      @(negedge mclk_i) chk("wfe standby", 32'h4, {28'h0, wes});
      @(posedge mclk_i) wake <= 1'b1;
      @(posedge mclk_i) wake <= 1'b0;
      @(negedge mclk_i) chk("wfe wake", 32'h0, {28'h0, wes});
      @(posedge mclk_i) wait_for_interrupt <= 4'h2;
      @(posedge mclk_i) wait_for_interrupt <= 4'h0;
      @(negedge mclk_i) chk("wfi standby", 32'h2, {28'h0, wis});
      @(posedge mclk_i) irq <= 4'h2;
      @(posedge mclk_i) irq <= 4'h0;
      @(negedge mclk_i) chk("wfi wake", 32'h0, {28'h0, wis});
      @(posedge mclk_i);
      for (int k = 0; k < 4; k++) begin
         pat <= (k == 0) ? 16'hFFFF : 16'(nx());
         go <= 1'b1;
         @(posedge mclk_i) go <= 1'b0;
         repeat (8) @(posedge mclk_i);
         for (int n = 0; n < 4; n++) begin
            ahb(1'b0, 8'(4 * n), 32'h0);
            chk("sysctl straps", exp_sc(pat, n), rdat);
            ahb(1'b0, 8'(8'h10 + 4 * n), 32'h0);
            chk("affinity", {20'h0, cfg[3:0], 8'(n)}, rdat);
         end
      end
      ahb(1'b0, csb_pkg::OFS_CFGBASE, 32'h0);
      chk("base", {base[18:0], 13'h0}, rdat);
      ahb(1'b0, csb_pkg::OFS_WIN_CTRL, 32'h0);
      chk("window on", 32'h1, rdat);
      ahb(1'b0, csb_pkg::OFS_WIN_LOW, 32'h0);
      chk("window low", {cfg[15:4], 20'h0}, rdat);
      ahb(1'b0, csb_pkg::OFS_WIN_HIGH, 32'h0);
      chk("window high", {cfg[27:16], 20'h0}, rdat);
      ahb(1'b0, 8'h3C, 32'h0);
      chk("unmapped", 32'h0, rdat);
      gl <= 1'b1;
      ahb(1'b1, 8'h00, 32'h1F);
      ahb(1'b0, 8'h00, 32'h0);
      chk("global lock", exp_sc(pat, 0) | 32'h10, rdat);
      chk("smp out", 32'h1, {28'h0, smp});
      gl <= 1'b0;
      lc <= 4'h3;
      ahb(1'b1, 8'h00, ~exp_sc(pat, 0));
      ahb(1'b1, 8'h04, ~exp_sc(pat, 1));
      ahb(1'b0, 8'h04, 32'h0);
      chk("core lock", exp_sc(pat, 1) | 32'h10, rdat);
      ahb(1'b0, 8'h00, 32'h0);
      chk("core lock 0", exp_sc(pat, 0) | 32'h10, rdat);
      lc <= 4'h0;
      ahb(1'b1, 8'h04, 32'h0A);
      ahb(1'b0, 8'h04, 32'h0);
      chk("unlocked", 32'h0A, rdat);
      send_event_instr <= 4'h5;
      @(posedge mclk_i) send_event_instr <= 4'h0;
      pc = 32'h0;
      repeat (14) @(posedge mclk_i) pc = pc + {31'h0, sevo};
      chk("event pulses", 32'h2, pc);
      // mid-run reset: outputs idle, window switch captured anew
      won <= 1'b0;
      rst_n_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      chk("reset rdata", 32'h0, hrd);
      chk("reset mode", 32'h0, {28'h0, smp});
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      ahb(1'b0, csb_pkg::OFS_WIN_CTRL, 32'h0);
      chk("window off", {31'h0, won}, rdat);
      conclude();
   end
endmodule : testbench
